//--- hw/ebpc_defs.vh
// Purpose: constants for the external bus pin control block
// Assumes: APB byte addresses, 32-bit data words
// Notes: definitions only
`ifndef EBPC_DEFS_VH
`define EBPC_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EBPC_OFF_CTRL 12'h000
`define EBPC_OFF_ACCESS 12'h004
`define EBPC_OFF_WDATA 12'h008
`define EBPC_OFF_RDATA 12'h00C
`define EBPC_OFF_MASK 12'h010
`define EBPC_OFF_FLAG 12'h014
`define EBPC_OFF_STATUS 12'h018
`define EBPC_OFF_VECTOR 12'h01C

// ----------------------------------------
// Control fields
// ----------------------------------------
`define EBPC_CTRL_KEEP_BIT 0
`define EBPC_CTRL_HOLD_BIT 1
`define EBPC_CTRL_GMASK_BIT 2
`define EBPC_CTRL_RESET 3'h5

// ----------------------------------------
// Access register fields
// ----------------------------------------
`define EBPC_ACC_SPACE_LSB 23
`define EBPC_ACC_WRITE_BIT 25
`define EBPC_SPACE_PROG 2'h0
`define EBPC_SPACE_DATA 2'h1
`define EBPC_SPACE_IO 2'h2

// ----------------------------------------
// Vectors and sizes
// ----------------------------------------
`define EBPC_NMI_VECTOR 16'hFF88
`define EBPC_INT_VECTOR_BASE 16'hFFC0
`define EBPC_DRIVE_CYCLES 2'h2

`endif

//--- hw/ebpc_top.v
// Purpose: pin-level control of the external address/data bus, acknowledge and ext interrupts
// Assumes: all inputs synchronous to pclk; APB slave with zero wait states
// Notes: bus holders are modelled as keeper registers feeding the pin outputs
//
// Summary of operation
// R1 - Low sixteen address lines carry program, data and I/O addresses.
// R2 - Upper seven address lines driven only for program space accesses.
// R3 - Whole address bus floats while in hold mode.
// R4 - Whole address bus floats while output-disable input is low.
// R5 - Wide host mode makes low eighteen address lines inputs for host.
// R6 - Floated address lines keep their last level without pull parts.
// R7 - Data lines move words for memory, I/O, or host port.
// R8 - Data bus floats unless outputting, and during reset or hold.
// R9 - Data bus floats while output-disable is low, whatever the access.
// R10 - Floated data lines hold their last driven level.
// R11 - Software turns the data bus keeper on or off.
// R12 - Acknowledge asserted on interrupt accept, vector on low address lines.
// R13 - Four external interrupts individually masked, prioritized by mask and global bit.
// R14 - Requests latch into flag register; software polls and clears by writing.
// R15 - Nonmaskable interrupt vectors to own location, never blocked; the code holds it pending while reset pin is low or in hold mode.
// R16 - Acknowledge output floats while output-disable is low.
// R17 - Low output-disable overrides every other pin drive condition.
//
// The placing of the registers and the APB slave port were left to the implementer.
`include "ebpc_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module ebpc_top #(
    parameter ADDR_W = 23,
    parameter DATA_W = 16,
    parameter NUM_INT = 4
) (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Device control pins
    input wire reset_pin_n,
    input wire output_disable_n,
    input wire wide_host_port_mode,
    // Address bus
    input wire [ADDR_W-1:0] addr_in,
    output reg [ADDR_W-1:0] addr_out,
    output reg [ADDR_W-1:0] addr_oe,
    // Data bus
    input wire [DATA_W-1:0] data_in,
    output reg [DATA_W-1:0] data_out,
    output reg [DATA_W-1:0] data_oe,
    // Interrupts
    input wire [NUM_INT-1:0] external_interrupt_inputs_n,
    input wire nmi_n,
    output reg interrupt_acknowledge_n,
    output reg interrupt_acknowledge_oe,
    // Host-port view
    output reg [17:0] host_addr_reg
);

// ----------------------------------------
// State
// ----------------------------------------
localparam ST_IDLE = 3'b001;
localparam ST_DRIVE = 3'b010;
localparam ST_ACK = 3'b100;

reg [2:0] state_reg;
reg [1:0] cnt_reg;
reg [2:0] ctrl_reg;
reg [25:0] access_reg;
reg [15:0] wdata_reg;
reg [15:0] rdata_reg;
reg [NUM_INT-1:0] interrupt_mask_reg;
reg [NUM_INT-1:0] interrupt_flag_reg;
reg [NUM_INT-1:0] int_prev_reg;
reg nmi_prev_reg;
reg nmi_pend_reg;
reg [15:0] vector_reg;
reg go_reg;
reg [ADDR_W-1:0] addr_keep_reg;
reg [DATA_W-1:0] data_keep_reg;

wire apb_wr = psel & penable & pwrite;
wire apb_rd = psel & penable & ~pwrite;
wire keeper_en = ctrl_reg[`EBPC_CTRL_KEEP_BIT];
wire hold_mode = ctrl_reg[`EBPC_CTRL_HOLD_BIT];
wire global_int_mode = ctrl_reg[`EBPC_CTRL_GMASK_BIT];
wire [1:0] acc_space = access_reg[`EBPC_ACC_SPACE_LSB+1:`EBPC_ACC_SPACE_LSB];
wire acc_write = access_reg[`EBPC_ACC_WRITE_BIT];
wire [NUM_INT-1:0] int_fall = int_prev_reg & ~external_interrupt_inputs_n;
wire nmi_fall = nmi_prev_reg & ~nmi_n;
wire [NUM_INT-1:0] int_ready = interrupt_flag_reg & interrupt_mask_reg;
// Write-one-clear strobe, shared so an accept cannot swallow a software clear
wire [NUM_INT-1:0] flag_clr = (apb_wr && paddr == `EBPC_OFF_FLAG)
    ? pwdata[NUM_INT-1:0] : {NUM_INT{1'b0}};

// ----------------------------------------
// Priority pick
// ----------------------------------------
reg [NUM_INT-1:0] take_mask;
reg [15:0] take_vector;
integer i;
always @* begin
    take_mask = {NUM_INT{1'b0}};
    take_vector = `EBPC_INT_VECTOR_BASE;
    // R13 lowest index wins
    for (i = NUM_INT - 1; i >= 0; i = i - 1) begin
        if (int_ready[i] && !global_int_mode) begin
            take_mask = {NUM_INT{1'b0}};
            take_mask[i] = 1'b1;
            take_vector = `EBPC_INT_VECTOR_BASE + (i[15:0] << 2);
        end
    end
end

// ----------------------------------------
// APB registers and sequencer
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_reg <= `EBPC_CTRL_RESET;
        access_reg <= 26'h0;
        wdata_reg <= 16'h0;
        rdata_reg <= 16'h0;
        interrupt_mask_reg <= {NUM_INT{1'b0}};
        interrupt_flag_reg <= {NUM_INT{1'b0}};
        int_prev_reg <= {NUM_INT{1'b1}};
        nmi_prev_reg <= 1'b1;
        nmi_pend_reg <= 1'b0;
        vector_reg <= 16'h0;
        go_reg <= 1'b0;
        state_reg <= ST_IDLE;
        cnt_reg <= 2'h0;
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        int_prev_reg <= external_interrupt_inputs_n;
        nmi_prev_reg <= nmi_n;
        pready <= psel & ~penable;
        pslverr <= 1'b0;
        if (apb_wr) begin
            case (paddr)
                `EBPC_OFF_CTRL: ctrl_reg <= pwdata[2:0];
                `EBPC_OFF_ACCESS: begin
                    access_reg <= pwdata[25:0];
                    go_reg <= 1'b1;
                end
                `EBPC_OFF_WDATA: wdata_reg <= pwdata[15:0];
                `EBPC_OFF_MASK: interrupt_mask_reg <= pwdata[NUM_INT-1:0];
                `EBPC_OFF_FLAG, `EBPC_OFF_STATUS, `EBPC_OFF_RDATA, `EBPC_OFF_VECTOR: ;
                default: pslverr <= psel & ~penable;
            endcase
        end
        if (psel && !penable) begin
            case (paddr)
                `EBPC_OFF_CTRL: prdata <= {29'h0, ctrl_reg};
                `EBPC_OFF_ACCESS: prdata <= {6'h0, access_reg};
                `EBPC_OFF_WDATA: prdata <= {16'h0, wdata_reg};
                `EBPC_OFF_RDATA: prdata <= {16'h0, rdata_reg};
                `EBPC_OFF_MASK: prdata <= {{(32-NUM_INT){1'b0}}, interrupt_mask_reg};
                `EBPC_OFF_FLAG: prdata <= {{(32-NUM_INT){1'b0}}, interrupt_flag_reg};
                `EBPC_OFF_STATUS: prdata <= {29'h0, state_reg};
                `EBPC_OFF_VECTOR: prdata <= {16'h0, vector_reg};
                default: begin
                    prdata <= 32'h0;
                    pslverr <= 1'b1;
                end
            endcase
        end
        // R14 latch, write-one clears, set wins
        interrupt_flag_reg <= (interrupt_flag_reg & ~flag_clr) | int_fall;
        if (nmi_fall)
            nmi_pend_reg <= 1'b1;
        case (state_reg)
            ST_IDLE: begin
                cnt_reg <= 2'h0;
                // R15 nmi ignores mask and global bit, waits while in reset or hold or while a drive or acknowledge runs
                if (nmi_pend_reg && reset_pin_n && !hold_mode) begin
                    nmi_pend_reg <= nmi_fall;
                    vector_reg <= `EBPC_NMI_VECTOR;
                    state_reg <= ST_ACK;
                end else if (|take_mask && reset_pin_n && !hold_mode) begin
                    // R13 accepted clears flag
                    interrupt_flag_reg <= (interrupt_flag_reg & ~flag_clr & ~take_mask) | int_fall;
                    vector_reg <= take_vector;
                    state_reg <= ST_ACK;
                end else if (go_reg && reset_pin_n && !hold_mode) begin
                    go_reg <= 1'b0;
                    state_reg <= ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                cnt_reg <= cnt_reg + 2'h1;
                if (cnt_reg == `EBPC_DRIVE_CYCLES - 2'h1) begin
                    // R7 capture read word
                    if (!acc_write)
                        rdata_reg <= data_in;
                    state_reg <= ST_IDLE;
                end
            end
            ST_ACK: begin
                cnt_reg <= cnt_reg + 2'h1;
                if (cnt_reg == `EBPC_DRIVE_CYCLES - 2'h1)
                    state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------
// Pin drive
// ----------------------------------------
reg [ADDR_W-1:0] addr_oe_next;
reg [ADDR_W-1:0] addr_next;
reg [DATA_W-1:0] data_oe_next;
reg [DATA_W-1:0] data_next;
reg ack_next;
always @* begin
    addr_oe_next = {ADDR_W{1'b0}};
    addr_next = addr_keep_reg;
    data_oe_next = {DATA_W{1'b0}};
    data_next = keeper_en ? data_keep_reg : {DATA_W{1'b0}};
    ack_next = 1'b1;
    if (state_reg == ST_DRIVE) begin
        // R1 low lines shared
        addr_oe_next[15:0] = 16'hFFFF;
        addr_next[15:0] = access_reg[15:0];
        // R2 upper lines for program space only
        if (acc_space == `EBPC_SPACE_PROG) begin
            addr_oe_next[ADDR_W-1:16] = {(ADDR_W-16){1'b1}};
            addr_next[ADDR_W-1:16] = access_reg[ADDR_W-1:16];
        end
        // R8 drive data only on writes
        if (acc_write) begin
            data_oe_next = {DATA_W{1'b1}};
            data_next = wdata_reg;
        end
    end else if (state_reg == ST_ACK) begin
        // R12 vector on low address
        addr_oe_next[15:0] = 16'hFFFF;
        addr_next[15:0] = vector_reg;
        ack_next = 1'b0;
    end
    // R5 host drives low eighteen lines
    if (wide_host_port_mode)
        addr_oe_next[17:0] = 18'h0;
    // R3 R8 hold and reset float
    if (hold_mode || !reset_pin_n) begin
        addr_oe_next = {ADDR_W{1'b0}};
        data_oe_next = {DATA_W{1'b0}};
        ack_next = 1'b1;
    end
    // R4 R9 R16 R17 disable overrides
    if (!output_disable_n) begin
        addr_oe_next = {ADDR_W{1'b0}};
        data_oe_next = {DATA_W{1'b0}};
    end
    // R6 R10 floated bits keep their level
    // An access suppressed by hold or disable must not leak onto the holders
    addr_next = (addr_next & addr_oe_next) | (addr_keep_reg & ~addr_oe_next);
    if (data_oe_next == {DATA_W{1'b0}})
        data_next = keeper_en ? data_keep_reg : {DATA_W{1'b0}};
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        addr_out <= {ADDR_W{1'b0}};
        addr_oe <= {ADDR_W{1'b0}};
        data_out <= {DATA_W{1'b0}};
        data_oe <= {DATA_W{1'b0}};
        addr_keep_reg <= {ADDR_W{1'b0}};
        data_keep_reg <= {DATA_W{1'b0}};
        interrupt_acknowledge_n <= 1'b1;
        interrupt_acknowledge_oe <= 1'b0;
        host_addr_reg <= 18'h0;
    end else begin
        addr_oe <= addr_oe_next;
        data_oe <= data_oe_next;
        // R6 address holder keeps last level
        addr_out <= addr_next;
        addr_keep_reg <= addr_next;
        // R10 R11 data keeper when enabled
        data_out <= data_next;
        if (|data_oe_next)
            data_keep_reg <= data_next;
        interrupt_acknowledge_n <= ack_next;
        // R16 acknowledge floats when disabled
        interrupt_acknowledge_oe <= output_disable_n;
        if (wide_host_port_mode)
            host_addr_reg <= addr_in[17:0];
    end
end

endmodule // ebpc_top

`default_nettype wire

//--- tb/ebpc_checker.sv
// Purpose: pin behaviour checker for ebpc_top
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every ebpc_top instance
`timescale 1ns/1ns
`default_nettype none
module ebpc_checker #(
    parameter ADDR_W = 23,
    parameter DATA_W = 16,
    parameter NUM_INT = 4
) (
    // Clock and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic reset_pin_n,
    input wire logic output_disable_n,
    input wire logic wide_host_port_mode,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic [ADDR_W-1:0] addr_oe,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic [DATA_W-1:0] data_oe,
    input wire logic interrupt_acknowledge_n,
    input wire logic interrupt_acknowledge_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // Pin and APB rules
    // ----
    off_float_a: assert property (!output_disable_n |=> addr_oe == '0 && data_oe == '0)
        else $error("pins driven while output disable low");
    ack_float_a: assert property (!output_disable_n |=> !interrupt_acknowledge_oe)
        else $error("acknowledge driven while output disable low");
    rst_float_a: assert property (!reset_pin_n |=> data_oe == '0)
        else $error("data driven during device reset");
    wide_in_a: assert property (wide_host_port_mode |=> addr_oe[17:0] == 18'h0)
        else $error("low address driven in wide host mode");
    upper_prog_a: assert property (!wide_host_port_mode && !$past(wide_host_port_mode)
        && addr_oe[22:16] != 7'h0 |-> addr_oe[15:0] == 16'hFFFF)
        else $error("upper address driven without low address");
    addr_hold_a: assert property (addr_oe == '0 && $past(addr_oe) == '0 && !wide_host_port_mode
        |-> $stable(addr_out))
        else $error("floated address lost its level");
    data_hold_a: assert property (data_oe == '0 && $past(data_oe) == '0 && data_out != '0
        && $past(data_out) != '0 |-> $stable(data_out))
        else $error("floated data lost its level");
    ack_pulse_a: assert property ($fell(interrupt_acknowledge_n)
        |=> !interrupt_acknowledge_n ##1 interrupt_acknowledge_n)
        else $error("acknowledge pulse not two cycles");
    ack_vec_a: assert property (!interrupt_acknowledge_n |-> addr_out[15:8] == 8'hFF)
        else $error("no vector address during acknowledge");
    apb_wait_a: assert property (psel && !penable |=> pready)
        else $error("access phase not answered at once");
    apb_err_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // ebpc_checker
bind ebpc_top ebpc_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .NUM_INT(NUM_INT)) u_ebpc_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n), .output_disable_n(output_disable_n),
    .wide_host_port_mode(wide_host_port_mode), .addr_out(addr_out), .addr_oe(addr_oe),
    .data_out(data_out), .data_oe(data_oe), .interrupt_acknowledge_n(interrupt_acknowledge_n),
    .interrupt_acknowledge_oe(interrupt_acknowledge_oe));
`default_nettype wire

//--- tb/ebpc_ext_mem.sv
// Purpose: external memory on the far side of the pin bus
// Assumes: sixteen words picked by the low address lines
// Notes: a released data bus shows the inverse of its last word
`timescale 1ns/1ns
`default_nettype none
module ebpc_ext_mem (
    // Clock
    input wire logic pclk,
    // From the device
    input wire logic [22:0] addr_out,
    input wire logic [22:0] addr_oe,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe,
    // To the device
    output logic [15:0] data_in
);
    logic [15:0] mem [0:15];
    logic [15:0] last = 16'h0;
    wire rd = addr_oe[0] && data_oe == 16'h0;
    always @(posedge pclk) begin
        if (data_oe[0]) mem[addr_out[3:0]] <= data_out;
        if (rd) last <= data_in;
    end
    // Never echo the last word once released
    assign data_in = rd ? mem[addr_out[3:0]] : ~last;
endmodule // ebpc_ext_mem
`default_nettype wire

//--- tb/ebpc_top_tb.sv
// Purpose: self-checking bench for ebpc_top
// Assumes: zero-wait APB, registered pins
// Notes: expected words come from the bench memory model
`timescale 1ns/1ns
`default_nettype none
`include "ebpc_defs.vh"
module ebpc_top_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic err;
    logic pready, pslverr, reset_pin_n = 1'b1, output_disable_n = 1'b1, nmi_n = 1'b1;
    logic wide_host_port_mode = 1'b0, interrupt_acknowledge_n, interrupt_acknowledge_oe;
    logic [22:0] addr_in = 23'h0, addr_out, addr_oe;
    logic [15:0] data_in, data_out, data_oe;
    logic [3:0] external_interrupt_inputs_n = 4'hF;
    logic [17:0] host_addr_reg;
    integer fails = 0, tests_run = 0, seed = 4646, i, k;
    integer mem_model [0:2];
    always #10 pclk = ~pclk;
    ebpc_top u_ebpc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .reset_pin_n, .output_disable_n, .wide_host_port_mode, .addr_in,
        .addr_out, .addr_oe, .data_in, .data_out, .data_oe, .external_interrupt_inputs_n,
        .nmi_n, .interrupt_acknowledge_n, .interrupt_acknowledge_oe, .host_addr_reg);
    ebpc_ext_mem u_ebpc_ext_mem (.pclk, .addr_out, .addr_oe, .data_out, .data_oe, .data_in);
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Wait for driven address or for an acknowledge
    task till(input integer ack);
        k = 0;
        do begin
            @(negedge pclk);
            k = k + 1;
        end while (!(ack ? !interrupt_acknowledge_n : addr_oe[0]) && k < 30);
    endtask
    task pulse(input logic [3:0] m, input logic n);
        @(posedge pclk);
        external_interrupt_inputs_n <= ~m;
        nmi_n <= ~n;
        repeat (2) @(posedge pclk);
        external_interrupt_inputs_n <= 4'hF;
        nmi_n <= 1'b1;
    endtask
    task print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000;
        fails = fails + 1;
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`EBPC_OFF_CTRL, 32'h5);
        chk(err, 1'b0);
        rdc(12'h020, 32'h0);
        chk(err, 1'b1);
        for (i = 0; i < 3; i = i + 1) begin
            mem_model[i] = $random(seed) & 32'hFFFF;
            apb(1'b1, `EBPC_OFF_WDATA, mem_model[i]);
            apb(1'b1, `EBPC_OFF_ACCESS, (1 << 25) | (i << 23) | 32'h7F0000 | i);
            till(0);
            chk(addr_oe, i == 0 ? 32'h7FFFFF : 32'hFFFF);
            chk(addr_out[15:0], i);
            chk(data_out & data_oe, mem_model[i]);
            repeat (4) @(negedge pclk);
            chk(data_out + (data_oe << 16), mem_model[i]);
        end
        for (i = 0; i < 3; i = i + 1) begin
            apb(1'b1, `EBPC_OFF_ACCESS, (1 << 23) | i);
            till(0);
            chk(data_oe, 0);
            repeat (4) @(negedge pclk);
            rdc(`EBPC_OFF_RDATA, mem_model[i]);
        end
        apb(1'b1, `EBPC_OFF_CTRL, 32'h4);
        repeat (2) @(negedge pclk);
        chk(data_out, 0);
        for (i = 0; i < 2; i = i + 1) begin
            reset_pin_n <= ~i[0];
            apb(1'b1, `EBPC_OFF_CTRL, i ? 32'h4 : 32'h6);
            apb(1'b1, `EBPC_OFF_ACCESS, 32'h2000001);
            repeat (4) @(negedge pclk);
            chk(addr_oe | data_oe, 0);
            @(posedge pclk);
        end
        reset_pin_n <= 1'b1;
        apb(1'b1, `EBPC_OFF_CTRL, 32'h5);
        apb(1'b1, `EBPC_OFF_ACCESS, 32'h2000003);
        output_disable_n <= 1'b0;
        repeat (4) @(negedge pclk);
        chk(addr_oe | data_oe | interrupt_acknowledge_oe, 0);
        @(posedge pclk);
        output_disable_n <= 1'b1;
        // host drives the low address lines
        wide_host_port_mode <= 1'b1;
        addr_in <= 23'($random(seed));
        apb(1'b1, `EBPC_OFF_ACCESS, 32'h0000005);
        repeat (4) @(negedge pclk);
        chk(addr_oe[17:0] + (addr_in[17:0] ^ host_addr_reg), 0);
        @(posedge pclk);
        wide_host_port_mode <= 1'b0;
        pulse(4'h4, 1'b0);
        rdc(`EBPC_OFF_FLAG, 32'h4);
        apb(1'b1, `EBPC_OFF_FLAG, 32'h4);
        rdc(`EBPC_OFF_FLAG, 32'h0);
        apb(1'b1, `EBPC_OFF_MASK, 32'hA);
        pulse(4'hB, 1'b0);
        repeat (3) @(negedge pclk);
        chk(interrupt_acknowledge_n, 1);
        apb(1'b1, `EBPC_OFF_CTRL, 32'h1);
        for (i = 1; i < 4; i = i + 2) begin
            till(1);
            chk(addr_out[15:0], 32'hFFC0 + 4 * i);
            repeat (2) @(negedge pclk);
        end
        rdc(`EBPC_OFF_FLAG, 32'h1);
        rdc(`EBPC_OFF_VECTOR, 32'hFFCC);
        apb(1'b1, `EBPC_OFF_CTRL, 32'h5);
        pulse(4'h0, 1'b1);
        till(1);
        chk(addr_out[15:0], 32'hFF88);
        print_verdict;
    end
endmodule // ebpc_top_tb
`default_nettype wire
